//--- rtl/mode_ctrl_regs.vh
// constants for the operating mode control block
`ifndef MODE_CTRL_REGS_VH
`define MODE_CTRL_REGS_VH
`define RESET_VECTOR_HI 16'hFFFE
`define RESET_VECTOR_LO 16'hFFFF
`define MODE_RUN 3'h0
`define MODE_FETCH_HI 3'h1
`define MODE_FETCH_LO 3'h2
`define MODE_BACKGROUND 3'h3
`define MODE_WAIT 3'h4
`define MODE_STOP_FULL 3'h5
`define MODE_STOP_PART 3'h6
`define MODE_RESET 3'h7
`define RST_SRC_W 6
`endif

//--- rtl/sync2.v
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module sync2 (
    clk,
    d,
    q
);
    input wire clk;
    input wire d;
    output reg q;
    reg meta_r;
    // no reset: the flops must follow the pin through reset so its level is valid at release
    always @(posedge clk) begin
        meta_r <= d;
        q <= meta_r;
    end
endmodule

//--- rtl/operating_mode_control.v
// operating mode control: run, background, wait and stop sequencing
`timescale 1ns/1ps
`include "mode_ctrl_regs.vh"
module operating_mode_control (
    clk,
    reset_n,
    por_event,
    pin_reset_event,
    lvd_reset_event,
    cop_reset_event,
    ilop_reset_event,
    ilad_reset_event,
    debug_force_reset_register,
    debug_mode_select_pin_in,
    debug_mode_select_pin_out,
    debug_mode_select_pin_oe,
    halt_to_background_cmd,
    go_cmd,
    halt_to_debug_instruction,
    serial_debug_controller_bkpt,
    on_chip_trace_module_bkpt,
    wait_instruction,
    stop_instruction,
    stop_partial_select,
    wakeup_event,
    vector_addr,
    vector_fetch,
    cpu_run,
    background_active,
    sys_clk_enable,
    cpu_clk_enable,
    partial_power_down,
    ram_retain,
    mode_flag,
    reset_source
);
    input wire clk;
    input wire reset_n;
    input wire por_event;
    input wire pin_reset_event;
    input wire lvd_reset_event;
    input wire cop_reset_event;
    input wire ilop_reset_event;
    input wire ilad_reset_event;
    input wire debug_force_reset_register;
    input wire debug_mode_select_pin_in;
    output reg debug_mode_select_pin_out;
    output reg debug_mode_select_pin_oe;
    input wire halt_to_background_cmd;
    input wire go_cmd;
    input wire halt_to_debug_instruction;
    input wire serial_debug_controller_bkpt;
    input wire on_chip_trace_module_bkpt;
    input wire wait_instruction;
    input wire stop_instruction;
    input wire stop_partial_select;
    input wire wakeup_event;
    output reg [15:0] vector_addr;
    output reg vector_fetch;
    output reg cpu_run;
    output reg background_active;
    output reg sys_clk_enable;
    output reg cpu_clk_enable;
    output reg partial_power_down;
    output reg ram_retain;
    output reg mode_flag;
    output reg [`RST_SRC_W-1:0] reset_source;

    wire pin_sync;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg in_reset_r;
    reg force_pending_r;
    reg debug_req;

    sync2 u_pin_sync (
        .clk(clk),
        .d(debug_mode_select_pin_in),
        .q(pin_sync)
    );

    // the pin is only an input to this block; the debug host link drives it
    always @(posedge clk) begin
        debug_mode_select_pin_out <= 1'b0;
        debug_mode_select_pin_oe <= 1'b0;
    end

    // reset capture: in_reset_r marks the first clock after release
    always @(posedge clk) begin
        if (!reset_n) begin
            in_reset_r <= 1'b1;
            mode_flag <= 1'b1;
        end else begin
            in_reset_r <= 1'b0;
            if (in_reset_r) begin
                mode_flag <= pin_sync;
            end
        end
    end

    // reset sources: a debug-forced reset leaves no mark, so it stays invisible
    always @(posedge clk) begin
        if (!reset_n) begin
            reset_source <= 6'h00;
        end else if (por_event | pin_reset_event | lvd_reset_event | cop_reset_event |
                     ilop_reset_event | ilad_reset_event) begin
            reset_source <= {ilad_reset_event, ilop_reset_event, cop_reset_event,
                             lvd_reset_event, pin_reset_event, por_event};
        end
    end

    // the pending force must outlive reset_n; a new request wins over any clear
    always @(posedge clk) begin
        if (debug_force_reset_register) begin
            force_pending_r <= 1'b1;
        end else if (por_event | pin_reset_event | lvd_reset_event | cop_reset_event |
                     ilop_reset_event | ilad_reset_event) begin
            force_pending_r <= 1'b0;
        end else if (reset_n && (state_r == `MODE_RESET) && !in_reset_r) begin
            force_pending_r <= 1'b0; // consumed at reset exit
        end
    end

    always @* begin
        debug_req = halt_to_background_cmd
                  | halt_to_debug_instruction
                  | serial_debug_controller_bkpt
                  | on_chip_trace_module_bkpt;
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            `MODE_RESET: begin
                if (!in_reset_r) begin
                    if (!mode_flag || force_pending_r) begin
                        state_nxt = `MODE_BACKGROUND;
                    end else begin
                        state_nxt = `MODE_FETCH_HI;
                    end
                end
            end
            `MODE_FETCH_HI: state_nxt = `MODE_FETCH_LO;
            `MODE_FETCH_LO: state_nxt = `MODE_RUN;
            `MODE_RUN: begin
                if (debug_req) begin
                    state_nxt = `MODE_BACKGROUND;
                end else if (stop_instruction) begin
                    state_nxt = stop_partial_select ? `MODE_STOP_PART : `MODE_STOP_FULL;
                end else if (wait_instruction) begin
                    state_nxt = `MODE_WAIT;
                end
            end
            `MODE_BACKGROUND: begin
                if (go_cmd) begin
                    state_nxt = `MODE_RUN;
                end
            end
            `MODE_WAIT: begin
                if (halt_to_background_cmd) begin
                    state_nxt = `MODE_BACKGROUND;
                end else if (wakeup_event) begin
                    state_nxt = `MODE_RUN;
                end
            end
            `MODE_STOP_FULL: begin
                if (wakeup_event) begin
                    state_nxt = `MODE_RUN;
                end
            end
            `MODE_STOP_PART: begin
                // partial power down loses cpu context; wake goes through the vector
                if (wakeup_event) begin
                    state_nxt = `MODE_FETCH_HI;
                end
            end
            default: state_nxt = `MODE_RESET;
        endcase
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            state_r <= `MODE_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // registered decode of the next state keeps every output on a flop
    always @(posedge clk) begin
        if (!reset_n) begin
            vector_addr <= 16'h0000;
            vector_fetch <= 1'b0;
            cpu_run <= 1'b0;
            background_active <= 1'b0;
            sys_clk_enable <= 1'b1;
            cpu_clk_enable <= 1'b0;
            partial_power_down <= 1'b0;
            ram_retain <= 1'b1;
        end else begin
            vector_fetch <= (state_nxt == `MODE_FETCH_HI) || (state_nxt == `MODE_FETCH_LO);
            vector_addr <= (state_nxt == `MODE_FETCH_LO) ? `RESET_VECTOR_LO
                                                         : `RESET_VECTOR_HI;
            cpu_run <= (state_nxt == `MODE_RUN);
            background_active <= (state_nxt == `MODE_BACKGROUND);
            cpu_clk_enable <= (state_nxt == `MODE_RUN) || (state_nxt == `MODE_FETCH_HI) ||
                              (state_nxt == `MODE_FETCH_LO);
            sys_clk_enable <= (state_nxt != `MODE_STOP_FULL) &&
                              (state_nxt != `MODE_STOP_PART);
            partial_power_down <= (state_nxt == `MODE_STOP_PART);
            ram_retain <= 1'b1;
        end
    end
endmodule

//--- verif/mode_ctrl_sva.sv
// concurrent checks on the mode control ports
`timescale 1ns/1ps
module mode_ctrl_sva (
    input wire clk,
    input wire reset_n,
    input wire halt_to_background_cmd,
    input wire halt_to_debug_instruction,
    input wire serial_debug_controller_bkpt,
    input wire on_chip_trace_module_bkpt,
    input wire wait_instruction,
    input wire stop_instruction,
    input wire stop_partial_select,
    input wire [15:0] vector_addr,
    input wire vector_fetch,
    input wire cpu_run,
    input wire background_active,
    input wire sys_clk_enable,
    input wire cpu_clk_enable,
    input wire partial_power_down,
    input wire ram_retain
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // debug requests outrank stop and wait, so those checks exclude them
    wire dbg = halt_to_background_cmd | halt_to_debug_instruction | serial_debug_controller_bkpt
        | on_chip_trace_module_bkpt;
    wire stp = cpu_run && stop_instruction && !dbg;
    a_instr_halt: assert property (cpu_run && halt_to_debug_instruction |->
        ##[1:2] background_active && !cpu_run) else $error("halt instruction ignored");
    a_cmd_halt: assert property (cpu_run && halt_to_background_cmd |->
        ##[1:2] background_active && !cpu_run) else $error("host halt ignored");
    a_serial_break: assert property (cpu_run && serial_debug_controller_bkpt |->
        ##[1:2] background_active) else $error("serial breakpoint ignored");
    a_trace_break: assert property (cpu_run && on_chip_trace_module_bkpt |->
        ##[1:2] background_active) else $error("trace breakpoint ignored");
    a_bg_suspend: assert property (background_active |-> !cpu_run && !cpu_clk_enable)
        else $error("cpu active in background");
    a_wait_gate: assert property (cpu_run && wait_instruction && !dbg && !stop_instruction
        |-> ##[1:2] !cpu_clk_enable && sys_clk_enable) else $error("wait clocks wrong");
    a_stop_full: assert property (stp && !stop_partial_select |->
        ##[1:2] !sys_clk_enable && !partial_power_down) else $error("full stop wrong");
    a_stop_part: assert property (stp && stop_partial_select |->
        ##[1:2] partial_power_down && ram_retain && !sys_clk_enable) else $error("partial stop");
    a_vector_pair: assert property ($rose(vector_fetch) |-> vector_addr == 16'hFFFE
        ##1 vector_addr == 16'hFFFF) else $error("vector fetch order wrong");
endmodule
bind operating_mode_control mode_ctrl_sva chk (.clk, .reset_n, .halt_to_background_cmd,
    .halt_to_debug_instruction, .serial_debug_controller_bkpt, .on_chip_trace_module_bkpt,
    .wait_instruction, .stop_instruction, .stop_partial_select, .vector_addr, .vector_fetch,
    .cpu_run, .background_active, .sys_clk_enable, .cpu_clk_enable, .partial_power_down,
    .ram_retain);

//--- verif/debug_host.sv
// external debug host on the mode select pin
`timescale 1ns/1ps
module debug_host (
    input wire clk,
    input wire hold_low,
    input wire send_halt,
    output wire pin,
    output reg halt_cmd = 1'b0
);
    // pin has a pull-up, so released means high
    assign pin = hold_low ? 1'b0 : 1'b1;
    always @(posedge clk) halt_cmd <= send_halt;
endmodule

//--- verif/tb.sv
// self-checking bench for the mode control block
`timescale 1ns/1ps
module tb;
    localparam logic [3:0] RUN = 4'h6, BG = 4'hA, WT = 4'h2, SF = 4'h0, SP = 4'h1, NONE = 4'hC;
    reg clk = 0, reset_n = 0, sel = 0, hl = 0;
    // power-on pulse clears any stale force request before the first exit
    reg [14:0] ev = 15'h0001;
    wire pin, hcmd, oe, po, vf, run, bg, sck, cck, ppd, ram, mf;
    wire [15:0] va;
    wire [5:0] rs;
    logic [3:0] q[$];
    logic [3:0] pv = 4'h2;
    logic vfp = 1'b0;
    logic [31:0] lf = 32'h0000_1158;
    int n_fail = 0, check_count = 0, k;
    wire [3:0] cur = {bg, cck, sck, ppd};
    always #12.5 clk = ~clk;
    debug_host host (.clk(clk), .hold_low(hl), .send_halt(ev[14]), .pin(pin), .halt_cmd(hcmd));
    operating_mode_control uut (.clk(clk), .reset_n(reset_n), .por_event(ev[0]),
        .pin_reset_event(ev[1]), .lvd_reset_event(ev[2]), .cop_reset_event(ev[3]),
        .ilop_reset_event(ev[4]), .ilad_reset_event(ev[5]), .debug_force_reset_register(ev[6]),
        .debug_mode_select_pin_in(pin), .debug_mode_select_pin_out(po),
        .debug_mode_select_pin_oe(oe),
        .halt_to_background_cmd(hcmd), .go_cmd(ev[7]), .halt_to_debug_instruction(ev[8]),
        .serial_debug_controller_bkpt(ev[9]), .on_chip_trace_module_bkpt(ev[10]),
        .wait_instruction(ev[11]), .stop_instruction(ev[12]), .stop_partial_select(sel),
        .wakeup_event(ev[13]), .vector_addr(va), .vector_fetch(vf), .cpu_run(run),
        .background_active(bg), .sys_clk_enable(sck), .cpu_clk_enable(cck),
        .partial_power_down(ppd), .ram_retain(ram), .mode_flag(mf), .reset_source(rs));
    task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // mode changes are compared off-edge; fetch cycles are transient and skipped
    always @(negedge clk) begin
        // hold the last settled mode across fetch cycles so run entry still shows as a change
        if (!vf) pv <= cur;
        vfp <= vf;
        if (reset_n && vf) chk("vector", vfp ? 16'hFFFF : 16'hFFFE, va);
        if (reset_n && !vf && cur !== pv) begin
            if (q.size() == 0) chk("mode", 16'hFFFF, cur);
            else chk("mode", q.pop_front(), cur);
        end
    end
    task wq;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 40 && q.size() > 0; i++) @(posedge clk);
        if (q.size() > 0) begin
            n_fail++;
            report_and_stop;
        end
    endtask
    task hit(input int b, input logic [3:0] e);
        if (e != NONE) q.push_back(e);
        @(posedge clk) ev[b] <= 1'b1;
        @(posedge clk) ev[b] <= 1'b0;
        wq();
    endtask
    task rst(input logic h, input logic [3:0] e);
        q.push_back(e);
        @(posedge clk) hl <= h;
        reset_n <= 1'b0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        ev[0] <= 1'b0;
        wq();
    endtask
    initial begin
        rst(0, RUN);
        chk("flag", 1, mf);
        chk("oe", 0, oe);
        chk("pin_out", 0, po);
        chk("source", 0, rs);
        hit(8, BG);
        hit(11, NONE);
        hit(7, RUN);
        hit(9, BG);
        hit(7, RUN);
        hit(10, BG);
        hit(7, RUN);
        hit(14, BG);
        hit(7, RUN);
        hit(7, NONE);
        hit(11, WT);
        hit(14, BG);
        hit(7, RUN);
        sel <= 1'b0;
        hit(12, SF);
        hit(13, RUN);
        sel <= 1'b1;
        hit(12, SP);
        chk("ram", 1, ram);
        hit(13, RUN);
        repeat (6) begin
            lf = lfsr_next(lf);
            k = lf % 6;
            hit(k, NONE);
            chk("source", 6'h01 << k, rs);
        end
        hit(6, NONE);
        chk("source", 6'h01 << k, rs);
        rst(0, BG);
        chk("flag", 1, mf);
        rst(1, BG);
        chk("flag", 0, mf);
        report_and_stop;
    end
endmodule
